// ---- chgsup_pkg.sv ----
// chgsup_pkg: constants for the charger supervisor sequencer
// assumes a 125 MHz core clock and millivolt / milliamp coded inputs
package chgsup_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ           = 125_000_000;
  localparam int unsigned STEP_TIME_US     = 1000;      // one soft-start step
  localparam int unsigned DEGLITCH_TIME_MS = 1000;      // shorted-pack deglitch
  localparam int unsigned STEP_CYC         = CLK_HZ / 1_000_000 * STEP_TIME_US;
  localparam int unsigned DEGLITCH_CYC     = CLK_HZ / 1000 * DEGLITCH_TIME_MS;
  localparam int unsigned SS_STEPS         = 8;

  // register offsets (word index on the plain port)
  localparam logic [7:0] REG_MODE    = 8'h12;
  localparam logic [7:0] REG_CURRENT = 8'h14;
  localparam logic [7:0] REG_VOLTAGE = 8'h15;
  localparam logic [7:0] REG_STATUS  = 8'h16;

  // reset values
  localparam logic [15:0] MODE_RST    = 16'h0000;
  localparam logic [15:0] CURRENT_RST = 16'h0000;
  localparam logic [15:0] VOLTAGE_RST = 16'h0000;

  // field positions
  localparam int unsigned MODE_MON_SEL_BIT = 3;
  localparam int unsigned MODE_DEP_LSB     = 9;
  localparam int unsigned MODE_DEP_MSB     = 11;
  localparam int unsigned CUR_LSB          = 7;
  localparam int unsigned CUR_MSB          = 13;
  localparam int unsigned ST_VOR_BIT       = 0;
  localparam int unsigned ST_SHORT_BIT     = 1;
  localparam int unsigned ST_THERM_BIT     = 2;
  localparam int unsigned ST_SUSP_BIT      = 3;
  localparam int unsigned ST_CHG_BIT       = 4;

  // voltage window edges, mV
  localparam logic [15:0] V_WAKE_MV   = 16'h2328;   // 9000
  localparam logic [15:0] V_3C_LO_MV  = 16'h2EE0;   // 12000
  localparam logic [15:0] V_3C_HI_MV  = 16'h3840;   // 14400
  localparam logic [15:0] V_4C_LO_MV  = 16'h3E80;   // 16000
  localparam logic [15:0] V_4C_HI_MV  = 16'h4B00;   // 19200
  localparam logic [15:0] V_4C_MAX_MV = 16'h4AE7;   // 19175
  localparam logic [15:0] CELL_BASE_MV = 16'h0FA0;  // 4000
  localparam logic [15:0] CELL_STEP_UV = 16'h186A;  // 6250 uV

  // threshold constants, mV
  localparam logic [15:0] DEP_BASE_MV   = 16'h0898; // 2200
  localparam logic [15:0] DEP_STEP_MV   = 16'h0064; // 100
  localparam logic [15:0] SHORT_IN_MV   = 16'h06A4; // 1700
  localparam logic [15:0] SHORT_OUT_MV  = 16'h076C; // 1900
  localparam logic [15:0] UVT_MV        = 16'h07D0; // 2000

  typedef enum logic [1:0] {
    CHGSUP_OFF  = 2'b00,
    CHGSUP_SUSP = 2'b01,
    CHGSUP_RAMP = 2'b10,
    CHGSUP_RUN  = 2'b11
  } chgsup_state_t;
endpackage : chgsup_pkg

// ---- chgsup_deglitch.sv ----
// chgsup_deglitch: hysteretic state that flips only after a held condition
// assumes synchronous comparator levels
`timescale 1ns/100ps
module chgsup_deglitch
  import chgsup_pkg::*;
#(
  parameter int unsigned HOLD_CYC = DEGLITCH_CYC
)(
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST_N,
  // conditions
  input  wire logic ENTER,
  input  wire logic LEAVE,
  // result
  output logic      STATE
);
  localparam int unsigned CW = $clog2(HOLD_CYC + 1);
  logic [CW-1:0] cnt_r;
  logic          state_r;
  wire           want = state_r ? LEAVE : ENTER;
  wire           done = (cnt_r == CW'(HOLD_CYC - 1));

  // counter restarts whenever the qualifying condition drops
  always_ff @(posedge CLK)
  begin
    if (!RST_N || !want || done)
      cnt_r <= '0;                              // [RULE25]
    else
      cnt_r <= cnt_r + 1'b1;
  end

  // flip after the full hold, both directions
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      state_r <= 1'b0;
    else if (want && done)
      state_r <= ~state_r;                      // [RULE17]
  end

  assign STATE = state_r;
endmodule : chgsup_deglitch

// ---- chgsup_sequencer.sv ----
// chgsup_sequencer: supervisory control of a synchronous buck charger
// assumes comparator inputs synchronous to CLK and a host on the plain port
`timescale 1ns/100ps
// What this block does
// [RULE1] voltage code decodes to 7-bit per-cell target, 6.25 mV steps from 4 V
// [RULE2] 12 V to below 14.4 V means three cells, 18.75 mV steps
// [RULE3] 16 V to below 19.2 V means four cells, 25 mV steps
// [RULE4] exactly 9 V is valid and counts as two cells for thresholds
// [RULE5] invalid voltage code sets the out-of-range status flag
// [RULE6] below 12 V except 9 V flags out of range and disables converter
// [RULE7] 14.4 V up to 16 V flags out of range and disables converter
// [RULE8] 19.2 V and above flags out of range, charges clamped at 19.175 V
// [RULE9] current reference ramps in eight equal steps on every charge entry
// [RULE10] each ramp step lasts about one millisecond
// [RULE11] high side off at once on fault, undervoltage, sleep or low supply
// [RULE12] mode bit 3 picks charge (1) or input (0) current monitor
// [RULE13] charge current above twice setting drops high side, auto resumes
// [RULE14] pack below 2 V kills both switches and zeroes duty, then resumes
// [RULE15] over-temperature shuts converter until cool indication arrives
// [RULE16] mode bits 9-11 set depleted threshold 2.2 V plus 100 mV, times cells
// [RULE17] shorted pack below 1.7 V/cell, leaves above 1.9 V/cell, 1 s deglitch
// [RULE18] shorted pack charges at one eighth of programmed current
// [RULE19] charge starts only with pack temperature inside low-high window
// [RULE20] while charging, leaving low-cutoff window suspends until low-high window
// [RULE21] suspension turns off both power switches
// [RULE22] host decides charge start and stop via current and voltage settings
// [RULE23] zero current code disables charger, nonzero enables
// [RULE24] only current code bits 7-13 count, 128 mA each
// [RULE25] step and deglitch timers are clock counters restarted on condition loss
module chgsup_sequencer
  import chgsup_pkg::*;
#(
  parameter int unsigned STEP_CYCLES     = STEP_CYC,
  parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYC
)(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [15:0]      REG_RDATA,
  // analog comparators and sense
  input  wire logic [15:0] PACK_VOLTAGE_SENSE_MV,
  input  wire logic        ADAPTER_BELOW_PACK,
  input  wire logic        SUPPLY_UVLO,
  input  wire logic        CHARGE_OVERCURRENT,
  input  wire logic        DIE_HOT,
  input  wire logic        DIE_COOL,
  input  wire logic        TEMP_ABOVE_LOW_LIMIT,
  input  wire logic        TEMP_BELOW_HIGH_LIMIT,
  input  wire logic        TEMP_BELOW_CUTOFF_LIMIT,
  // gate drive and references
  output logic             HIGH_SIDE_EN,
  output logic             LOW_SIDE_EN,
  output logic             DUTY_RESET,
  output logic [6:0]       CURRENT_REF,
  output logic [15:0]      VOLTAGE_TARGET_MV,
  output logic [6:0]       CELL_TARGET_CODE,
  output logic [2:0]       CELL_COUNT,
  output logic [15:0]      DEPLETED_PACK_THRESHOLD_MV,
  output logic             SHORTED_PACK_CONDITION,
  output logic             MONITOR_SOURCE_SELECT,
  output logic             VOLTAGE_OUT_OF_RANGE_FLAG
);
  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0]   mode_r;
  logic [15:0]   current_r;
  logic [15:0]   voltage_r;
  logic [15:0]   rdata_r;

  // host writes; no side effects beyond storage
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      mode_r    <= MODE_RST;
      current_r <= CURRENT_RST;
      voltage_r <= VOLTAGE_RST;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == REG_MODE)    mode_r    <= REG_WDATA;
      if (REG_ADDR == REG_CURRENT) current_r <= REG_WDATA;  // [RULE22]
      if (REG_ADDR == REG_VOLTAGE) voltage_r <= REG_WDATA;  // [RULE22]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // voltage decode
  wire [15:0] v_code = voltage_r;
  wire is_wake  = (v_code == V_WAKE_MV);                                      // [RULE4]
  wire is_3cell = (v_code >= V_3C_LO_MV) && (v_code < V_3C_HI_MV);            // [RULE2]
  wire is_4cell = (v_code >= V_4C_LO_MV) && (v_code < V_4C_HI_MV);            // [RULE3]
  wire is_high  = (v_code >= V_4C_HI_MV);                                     // [RULE8]
  wire v_bad_off = !is_wake && !is_3cell && !is_4cell && !is_high;            // [RULE6] [RULE7]
  wire v_oor     = !is_wake && !is_3cell && !is_4cell;                        // [RULE5]

  wire [2:0]  cells = is_wake ? 3'h2 : (is_3cell ? 3'h3 : 3'h4);
  wire [15:0] clamped_mv = is_high ? V_4C_MAX_MV : v_code;                     // [RULE8]
  // steps of cells x 6.25 mV above cells x 4 V, limited to 7 bits; one divide of
  // the pack value keeps the top step that a truncated per-cell mV would lose
  wire [15:0] base_pack  = 16'(CELL_BASE_MV * 16'(cells));
  wire [15:0] above_base = (clamped_mv > base_pack) ? 16'(clamped_mv - base_pack) : 16'h0000;
  wire [31:0] step_idx   = (32'(above_base) * 32'h0000_03E8) / (32'(CELL_STEP_UV) * 32'(cells));
  wire [6:0]  cell_code  = (step_idx > 32'h0000_007F) ? 7'h7F : step_idx[6:0];  // [RULE1]

  //////////////////////////////////////////////////////////////////////////////
  // pack thresholds
  wire [2:0]  dep_sel  = mode_r[MODE_DEP_MSB:MODE_DEP_LSB];
  wire [15:0] dep_cell = 16'(DEP_BASE_MV + 16'(dep_sel) * DEP_STEP_MV);
  wire [15:0] dep_pack = 16'(dep_cell * 16'(cells));                           // [RULE16]
  wire [15:0] short_in_pack  = 16'(SHORT_IN_MV * 16'(cells));
  wire [15:0] short_out_pack = 16'(SHORT_OUT_MV * 16'(cells));
  wire        below_short = PACK_VOLTAGE_SENSE_MV < short_in_pack;
  wire        above_short = PACK_VOLTAGE_SENSE_MV > short_out_pack;
  wire        pack_uv     = PACK_VOLTAGE_SENSE_MV < UVT_MV;                    // [RULE14]
  logic       shorted;

  chgsup_deglitch #(
    .HOLD_CYC (DEGLITCH_CYCLES)
  ) u_short (
    .CLK   (CLK),
    .RST_N (RST_N),
    .ENTER (below_short),
    .LEAVE (above_short),
    .STATE (shorted)
  );

  //////////////////////////////////////////////////////////////////////////////
  // enables and qualification
  wire [6:0] cur_code   = current_r[CUR_MSB:CUR_LSB];                          // [RULE24]
  wire       chg_req    = (cur_code != 7'h00) && !v_bad_off;                   // [RULE23] [RULE6] [RULE7]
  wire       start_ok   = TEMP_ABOVE_LOW_LIMIT && TEMP_BELOW_HIGH_LIMIT;       // [RULE19]
  wire       run_ok     = TEMP_ABOVE_LOW_LIMIT && TEMP_BELOW_CUTOFF_LIMIT;     // [RULE20]
  logic      therm_r;

  // thermal latch: hot sets, cool clears; hot wins if both
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      therm_r <= 1'b0;
    else if (DIE_HOT)
      therm_r <= 1'b1;                          // [RULE15]
    else if (DIE_COOL)
      therm_r <= 1'b0;                          // [RULE15]
  end

  wire fault = therm_r || DIE_HOT || SUPPLY_UVLO || ADAPTER_BELOW_PACK;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  localparam int unsigned SCW = $clog2(STEP_CYCLES + 1);
  chgsup_state_t state_r, state_nxt;
  logic [SCW-1:0] step_cnt_r;
  logic [3:0]     step_r;
  wire            step_done = (step_cnt_r == SCW'(STEP_CYCLES - 1));
  wire            in_charge = (state_r == CHGSUP_RAMP) || (state_r == CHGSUP_RUN);

  // next state; any exit from charge restarts the ramp on re-entry
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      CHGSUP_OFF:  if (chg_req) state_nxt = CHGSUP_SUSP;
      CHGSUP_SUSP:
        if (!chg_req)
          state_nxt = CHGSUP_OFF;
        else if (start_ok && !fault)
          state_nxt = CHGSUP_RAMP;              // [RULE19] [RULE20]
      CHGSUP_RAMP, CHGSUP_RUN:
        if (!chg_req)
          state_nxt = CHGSUP_OFF;
        else if (!run_ok || fault)
          state_nxt = CHGSUP_SUSP;              // [RULE20]
        else if (state_r == CHGSUP_RAMP && step_done && step_r == 4'(SS_STEPS - 1))
          state_nxt = CHGSUP_RUN;
      default:     state_nxt = CHGSUP_OFF;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      state_r <= CHGSUP_OFF;
    else
      state_r <= state_nxt;
  end

  // step timer: restarts on leaving the ramp
  always_ff @(posedge CLK)
  begin
    if (!RST_N || state_nxt != CHGSUP_RAMP || state_r != CHGSUP_RAMP || step_done)
      step_cnt_r <= '0;                         // [RULE25] [RULE10]
    else
      step_cnt_r <= step_cnt_r + 1'b1;
  end

  // step index: 0..7 during ramp, 8 only in the cycle after the last step, else 0
  always_ff @(posedge CLK)
  begin
    if (!RST_N || state_r != CHGSUP_RAMP)
      step_r <= '0;                             // [RULE9]
    else if (step_done && step_r != 4'(SS_STEPS))
      step_r <= step_r + 1'b1;                  // [RULE9]
  end

  // reference: (step+1)/8 of setting while ramping; C/8 when shorted
  wire [6:0]  full_cur = shorted ? {3'h0, cur_code[6:3]} : cur_code;           // [RULE18]
  wire [10:0] ramp_mul = 11'(full_cur) * 11'(step_r + 4'h1);
  wire [6:0]  ref_cur  = (state_r == CHGSUP_RUN) ? full_cur : ramp_mul[9:3];

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  wire hs_kill = !in_charge || fault || pack_uv || CHARGE_OVERCURRENT;         // [RULE11] [RULE13]
  wire ls_kill = !in_charge || pack_uv;                                        // [RULE14] [RULE21]

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      HIGH_SIDE_EN <= 1'b0;
      LOW_SIDE_EN  <= 1'b0;
      DUTY_RESET   <= 1'b1;
      CURRENT_REF  <= 7'h00;
    end
    else
    begin
      HIGH_SIDE_EN <= !hs_kill;                 // [RULE11] [RULE21]
      LOW_SIDE_EN  <= !ls_kill;                 // [RULE21]
      DUTY_RESET   <= pack_uv || !in_charge;    // [RULE14]
      CURRENT_REF  <= in_charge ? ref_cur : 7'h00;
    end
  end

  // decoded values held in flops
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      VOLTAGE_TARGET_MV          <= 16'h0000;
      CELL_TARGET_CODE           <= 7'h00;
      CELL_COUNT                 <= 3'h0;
      DEPLETED_PACK_THRESHOLD_MV <= 16'h0000;
      SHORTED_PACK_CONDITION     <= 1'b0;
      MONITOR_SOURCE_SELECT      <= 1'b0;
      VOLTAGE_OUT_OF_RANGE_FLAG  <= 1'b0;
    end
    else
    begin
      VOLTAGE_TARGET_MV          <= clamped_mv;       // [RULE8]
      CELL_TARGET_CODE           <= cell_code;        // [RULE1]
      CELL_COUNT                 <= cells;            // [RULE4]
      DEPLETED_PACK_THRESHOLD_MV <= dep_pack;         // [RULE16]
      SHORTED_PACK_CONDITION     <= shorted;          // [RULE17]
      MONITOR_SOURCE_SELECT      <= mode_r[MODE_MON_SEL_BIT];  // [RULE12]
      VOLTAGE_OUT_OF_RANGE_FLAG  <= v_oor;            // [RULE5]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port; unmapped reads zero
  wire [15:0] status_w = 16'(v_oor)                      << ST_VOR_BIT
                       | 16'(shorted)                    << ST_SHORT_BIT
                       | 16'(therm_r)                    << ST_THERM_BIT
                       | 16'(state_r == CHGSUP_SUSP)     << ST_SUSP_BIT
                       | 16'(in_charge)                  << ST_CHG_BIT;
  wire [15:0] rd_mux = (REG_ADDR == REG_MODE)    ? mode_r    :
                       (REG_ADDR == REG_CURRENT) ? current_r :
                       (REG_ADDR == REG_VOLTAGE) ? voltage_r :
                       (REG_ADDR == REG_STATUS)  ? status_w  : 16'h0000;

  always_ff @(posedge CLK)
  begin
    if (!RST_N || !REG_RD)
      rdata_r <= 16'h0000;
    else
      rdata_r <= rd_mux;                        // [RULE5]
  end

  assign REG_RDATA = rdata_r;
endmodule : chgsup_sequencer

// ---- chgsup_sequencer_assertions.sv ----
// chgsup_sequencer_assertions: port-level checks of the charger supervisor
// assumes bind onto chgsup_sequencer, one clock, sync active-low reset
`timescale 1ns/100ps
module chgsup_seq_sva
  import chgsup_pkg::*;
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // register port
  input wire logic [7:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_WR,
  // sense levels
  input wire logic [15:0] PACK_VOLTAGE_SENSE_MV,
  input wire logic        ADAPTER_BELOW_PACK,
  input wire logic        SUPPLY_UVLO,
  input wire logic        CHARGE_OVERCURRENT,
  input wire logic        DIE_HOT,
  // watched outputs
  input wire logic        HIGH_SIDE_EN,
  input wire logic        LOW_SIDE_EN,
  input wire logic        DUTY_RESET,
  input wire logic [2:0]  CELL_COUNT,
  input wire logic        MONITOR_SOURCE_SELECT,
  input wire logic        VOLTAGE_OUT_OF_RANGE_FLAG
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  // write decodes; outputs follow a write two edges later
  wire logic vwr = REG_WR && (REG_ADDR == REG_VOLTAGE);
  wire logic mwr = REG_WR && (REG_ADDR == REG_MODE);
  wire logic mb3 = REG_WDATA[MODE_MON_SEL_BIT];
  property p_uvlo; SUPPLY_UVLO |=> !HIGH_SIDE_EN; endproperty
  a_uvlo: assert property (p_uvlo) else $error("high side on under low supply");
  property p_sleep; ADAPTER_BELOW_PACK |=> !HIGH_SIDE_EN; endproperty
  a_sleep: assert property (p_sleep) else $error("high side on in sleep");
  property p_oc; CHARGE_OVERCURRENT |=> !HIGH_SIDE_EN; endproperty
  a_oc: assert property (p_oc) else $error("high side on during overcurrent");
  property p_uvt; PACK_VOLTAGE_SENSE_MV < UVT_MV |=> !HIGH_SIDE_EN && !LOW_SIDE_EN && DUTY_RESET; endproperty
  a_uvt: assert property (p_uvt) else $error("switches on with pack below 2 V");
  property p_hot; DIE_HOT |=> !HIGH_SIDE_EN; endproperty
  a_hot: assert property (p_hot) else $error("high side on while die hot");
  property p_mode; mwr |=> ##1 MONITOR_SOURCE_SELECT == $past(mb3, 2); endproperty
  a_mode: assert property (p_mode) else $error("monitor select not from mode bit 3");
  property p_wake; vwr && REG_WDATA == V_WAKE_MV |=> ##1 !VOLTAGE_OUT_OF_RANGE_FLAG && CELL_COUNT == 3'h2; endproperty
  a_wake: assert property (p_wake) else $error("wake voltage not two valid cells");
  property p_low; vwr && REG_WDATA < V_3C_LO_MV && REG_WDATA != V_WAKE_MV |=> ##1 VOLTAGE_OUT_OF_RANGE_FLAG;
  endproperty
  a_low: assert property (p_low) else $error("low voltage code not flagged");
  property p_gap; vwr && REG_WDATA >= V_3C_HI_MV && REG_WDATA < V_4C_LO_MV |=> ##1 VOLTAGE_OUT_OF_RANGE_FLAG;
  endproperty
  a_gap: assert property (p_gap) else $error("gap voltage code not flagged");
  // main scenarios reached
  c_trip: cover property (HIGH_SIDE_EN ##1 !HIGH_SIDE_EN);
  c_wake: cover property (vwr && REG_WDATA == V_WAKE_MV);
  c_clear: cover property ($fell(VOLTAGE_OUT_OF_RANGE_FLAG));
endmodule : chgsup_seq_sva

bind chgsup_sequencer chgsup_seq_sva chgsup_seq_sva_i (.CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR,
  .PACK_VOLTAGE_SENSE_MV, .ADAPTER_BELOW_PACK, .SUPPLY_UVLO, .CHARGE_OVERCURRENT, .DIE_HOT, .HIGH_SIDE_EN,
  .LOW_SIDE_EN, .DUTY_RESET, .CELL_COUNT, .MONITOR_SOURCE_SELECT, .VOLTAGE_OUT_OF_RANGE_FLAG);

// ---- chgsup_stage_model.sv ----
// chgsup_stage_model: far-side comparators for pack and die temperature, overcurrent
// assumes whole-degree temperatures and current codes in reference units
`timescale 1ns/100ps
module chgsup_stage_model #(
  parameter int LOW_C    = 0,
  parameter int HIGH_C   = 45,
  parameter int CUTOFF_C = 60
)(
  // clock
  input wire logic              clk,
  // conditions set by the bench, and the current reference from the sequencer
  input wire logic signed [8:0] pack_c,
  input wire logic signed [8:0] die_c,
  input wire logic [6:0]        sense_code,
  input wire logic [6:0]        current_ref,
  // comparator levels
  output logic                  above_low,
  output logic                  below_high,
  output logic                  below_cutoff,
  output logic                  die_hot,
  output logic                  die_cool,
  output logic                  overcurrent
);
  // comparators resolve once a cycle so no level moves at the sampling edge
  always_ff @(posedge clk)
  begin
    above_low    <= pack_c > LOW_C;
    below_high   <= pack_c < HIGH_C;
    below_cutoff <= pack_c < CUTOFF_C;
    die_hot      <= die_c > 145;
    die_cool     <= die_c < 130;
    overcurrent  <= {1'b0, sense_code} > {current_ref, 1'b0};
  end
endmodule : chgsup_stage_model

// ---- test_chgsup_sequencer.sv ----
// test_chgsup_sequencer: directed bench for the charger supervisor
// assumes chgsup_pkg; step and deglitch counts shortened to 20 and 50
`timescale 1ns/100ps
module test_chgsup_sequencer
  import chgsup_pkg::*;
;
  typedef struct packed {logic [15:0] v; logic voltage_out_of_range_flag; logic [2:0] cells; logic [15:0] tgt;} chgsup_vcase_t;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, uvlo = 1'b0, sleep = 1'b0;
  logic [7:0]        addr = 8'h00;
  logic [15:0]       wdata = 16'h0000, pack_mv = 16'h3E80;
  logic signed [8:0] pack_c = 9'sh032, die_c = 9'sh019; // 50 C pack, 25 C die
  logic [6:0]        sense = 7'h00;
  wire logic [15:0]  rdata, vtgt, dep;
  wire logic         hs, ls, duty, shorted, mon, voltage_out_of_range_flag, a_low, b_high, b_cut, hot, cool, oc;
  wire logic [6:0]   cref, ccode;
  wire logic [2:0]   cells;
  int                fail_count = 0, checks = 0, cycles = 0;
  chgsup_vcase_t     vt [8] = '{'{16'h2328, 1'b0, 3'h2, 16'h0000}, '{16'h2EDF, 1'b1, 3'h0, 16'h0000},
    '{16'h2EE0, 1'b0, 3'h3, 16'h2EE0}, '{16'h382D, 1'b0, 3'h3, 16'h0000}, '{16'h3840, 1'b1, 3'h0, 16'h0000},
    '{16'h3E7F, 1'b1, 3'h0, 16'h0000}, '{16'h3E80, 1'b0, 3'h4, 16'h3E80}, '{16'h4B00, 1'b1, 3'h4, 16'h4AE7}};

  chgsup_sequencer #(.STEP_CYCLES(20), .DEGLITCH_CYCLES(50)) chgsup_sequencer_i (.CLK(clk), .RST_N(rst_n),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .PACK_VOLTAGE_SENSE_MV(pack_mv), .ADAPTER_BELOW_PACK(sleep), .SUPPLY_UVLO(uvlo), .CHARGE_OVERCURRENT(oc),
    .DIE_HOT(hot), .DIE_COOL(cool), .TEMP_ABOVE_LOW_LIMIT(a_low), .TEMP_BELOW_HIGH_LIMIT(b_high),
    .TEMP_BELOW_CUTOFF_LIMIT(b_cut), .HIGH_SIDE_EN(hs), .LOW_SIDE_EN(ls), .DUTY_RESET(duty), .CURRENT_REF(cref),
    .VOLTAGE_TARGET_MV(vtgt), .CELL_TARGET_CODE(ccode), .CELL_COUNT(cells), .DEPLETED_PACK_THRESHOLD_MV(dep),
    .SHORTED_PACK_CONDITION(shorted), .MONITOR_SOURCE_SELECT(mon), .VOLTAGE_OUT_OF_RANGE_FLAG(voltage_out_of_range_flag));
  chgsup_stage_model chgsup_stage_model_i (.clk(clk), .pack_c(pack_c), .die_c(die_c), .sense_code(sense),
    .current_ref(cref), .above_low(a_low), .below_high(b_high), .below_cutoff(b_cut), .die_hot(hot),
    .die_cool(cool), .overcurrent(oc));

  ////////////////////////////////////////
  // 125 MHz clock and a hang guard well above the expected run length
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe edge
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_reg
  // waits for the high side, then samples each 20-cycle step near its middle
  task automatic ramp();
    repeat (100) if (hs !== 1'b1) @(posedge clk);
    cyc(9);
    chk({15'h0000, hs}, 16'h0001);
    for (int k = 0; k < 8; k++)
    begin
      chk({9'h000, cref}, 16'(2 * (k + 1)));
      cyc(20);
    end
    chk({9'h000, cref}, 16'h0010);
  endtask : ramp
  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note
  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  ////////////////////////////////////////
  initial
  begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(2);
    chk({15'h0000, mon}, 16'h0000);
    chk({15'h0000, voltage_out_of_range_flag}, 16'h0001);
    rd_reg(REG_MODE, 16'h0000);
    rd_reg(8'h00, 16'h0000);
    note("reset");
    foreach (vt[i])
    begin
      wr_reg(REG_VOLTAGE, vt[i].v);
      cyc(3);
      chk({15'h0000, voltage_out_of_range_flag}, {15'h0000, vt[i].voltage_out_of_range_flag});
      if (vt[i].cells != 3'h0) chk({13'h0000, cells}, {13'h0000, vt[i].cells});
      if (vt[i].tgt != 16'h0000) chk(vtgt, vt[i].tgt);
    end
    chk({9'h000, ccode}, 16'h007F);
    note("voltage decode");
    wr_reg(REG_CURRENT, 16'hC07F);
    cyc(30);
    chk({15'h0000, hs}, 16'h0000);
    wr_reg(REG_CURRENT, 16'h0800);
    cyc(30);
    chk({15'h0000, hs}, 16'h0000);
    @(posedge clk);
    pack_c <= 9'sh019; // 25 C
    ramp();
    rd_reg(REG_STATUS, 16'h0011);
    wr_reg(REG_STATUS, 16'hFFFF);
    rd_reg(REG_STATUS, 16'h0011);
    note("start and ramp");
    wr_reg(REG_MODE, 16'h0A08);
    cyc(3);
    chk({15'h0000, mon}, 16'h0001);
    chk(dep, 16'h2A30);
    rd_reg(REG_MODE, 16'h0A08);
    note("mode");
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      uvlo  <= k == 0;
      sleep <= k == 1;
      sense <= (k == 2) ? 7'h28 : 7'h00; // 40 exceeds twice 16
      cyc(3);
      chk({15'h0000, hs}, 16'h0000);
      @(posedge clk);
      uvlo  <= 1'b0;
      sleep <= 1'b0;
      sense <= 7'h00;
      if (k == 2) cyc(4);
      if (k == 2) chk({15'h0000, hs}, 16'h0001);
      else ramp();
    end
    note("faults");
    @(posedge clk);
    die_c <= 9'sh096; // 150 C
    cyc(3);
    chk({15'h0000, hs}, 16'h0000);
    die_c <= 9'sh08C; // 140 C, still latched off
    cyc(30);
    chk({15'h0000, hs}, 16'h0000);
    die_c <= 9'sh064;
    ramp();
    pack_c <= 9'sh032; // 50 C: inside cutoff window
    cyc(30);
    chk({15'h0000, hs}, 16'h0001);
    pack_c <= 9'sh046; // 70 C
    cyc(4);
    chk({14'h0000, hs, ls}, 16'h0000);
    pack_c <= 9'sh032;
    cyc(30);
    chk({15'h0000, hs}, 16'h0000);
    pack_c <= 9'sh019;
    ramp();
    note("thermal");
    @(posedge clk) pack_mv <= 16'h05DC; // 1.5 V
    cyc(2);
    chk({13'h0000, hs, ls, duty}, 16'h0001);
    @(posedge clk) pack_mv <= 16'h3E80;
    cyc(4);
    chk({14'h0000, hs, duty}, 16'h0002);
    @(posedge clk) pack_mv <= 16'h1770; // 1.5 V per cell
    cyc(30);
    @(posedge clk) pack_mv <= 16'h3E80;
    cyc(1);
    @(posedge clk) pack_mv <= 16'h1770;
    cyc(40);
    chk({15'h0000, shorted}, 16'h0000);
    cyc(30);
    chk({15'h0000, shorted}, 16'h0001);
    chk({9'h000, cref}, 16'h0002);
    @(posedge clk) pack_mv <= 16'h1F40; // 2.0 V per cell
    cyc(40);
    chk({15'h0000, shorted}, 16'h0001);
    cyc(30);
    chk({15'h0000, shorted}, 16'h0000);
    chk({9'h000, cref}, 16'h0010);
    note("shorted pack");
    wr_reg(REG_CURRENT, 16'h0000);
    cyc(3);
    chk({15'h0000, hs}, 16'h0000);
    note("stop");
    close_out();
  end
endmodule : test_chgsup_sequencer
